// ===== src/rtc_trim_regs.sv
/*
 receiver trim configuration bank: wishbone slave, trim/monitor/adc outputs,
 rssi correction and data-rate acceptance check.
 assumes: rssi and rate inputs come from logic on clk; classic wishbone master.
 */
// What this block does
// R1: fine trim bits 3 and 2 switch 500 fF and 250 fF caps; reset zero.
// R2: fine trim bits 1 and 0 switch 125 fF and 62.5 fF caps.
// R3: monitor bit 0 enables the rssi pin buffer; resets enabled.
// R4: adc selector 000 rssi, 001 temperature, 010 half supply; others unused.
// R5: rssi offset code maps 00h to -256, ffh to 254, step two.
// R6: rssi slope multiplies rssi by code times 2^-7; 80h is unity.
// R7: positive threshold bounds accepted rate above nominal; reset 1eh.
// R8: negative threshold bounds accepted rate below nominal; reset 23h.
// R9: thresholds act only while the rate limit enable bit is set.
// R10: unused upper bits ignore writes and read zero.
`include "rtc_map.svh"

module rtc_trim_regs
	import rtc_pkg::*;
#(
	parameter int AW = 10
) (
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [AW-1:0]        wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire rtc_rssi_s            rssi_in,
	input  wire rtc_rate_s            rate_in,
	output rtc_trim_s                 trim_o,
	output logic                      rssi_pin_buffer_enable,
	output rtc_adc_route_s            adc_route_o,
	output logic signed [9:0]         rssi_offset_corr,
	output logic signed [10:0]        rssi_corrected,
	output logic                      rssi_corrected_valid,
	output logic                      rate_accept,
	output logic                      rate_accept_valid
);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic        ack_q;
	logic [31:0] rdata_q;
	logic [7:0]  fine_trim_q;
	logic [7:0]  mon_cfg_q;
	logic [7:0]  adc_sel_q;
	logic [7:0]  rssi_off_q;
	logic [7:0]  rssi_slope_q;
	logic [7:0]  rate_pos_q;
	logic [7:0]  rate_neg_q;
	logic [7:0]  cdr_ctrl_q;
	logic        rate_seen_q;

	wire       bus_req   = wb_cyc_i & wb_stb_i;
	wire       take      = bus_req & ~ack_q;
	wire [7:0] reg_idx   = wb_adr_i[9:2];
	wire       wr_strobe = bus_req & ack_q & wb_we_i & wb_sel_i[0];

	wire hit_fine  = reg_idx == `RTC_IDX_FINE_TRIM;
	wire hit_mon   = reg_idx == `RTC_IDX_MON_CFG;
	wire hit_adc   = reg_idx == `RTC_IDX_ADC_SEL;
	wire hit_off   = reg_idx == `RTC_IDX_RSSI_OFF;
	wire hit_slope = reg_idx == `RTC_IDX_RSSI_SLOPE;
	wire hit_pos   = reg_idx == `RTC_IDX_RATE_POS;
	wire hit_neg   = reg_idx == `RTC_IDX_RATE_NEG;
	wire hit_ctrl  = reg_idx == `RTC_IDX_CDR_CTRL;
	wire hit_stat  = reg_idx == `RTC_IDX_STATUS;

	wire [7:0] status_val = {6'h00, rate_seen_q, rate_accept};

	// unmapped indices read zero and swallow writes
	wire [7:0] rd_mux =
		hit_fine  ? fine_trim_q  :
		hit_mon   ? mon_cfg_q    :
		hit_adc   ? adc_sel_q    :
		hit_off   ? rssi_off_q   :
		hit_slope ? rssi_slope_q :
		hit_pos   ? rate_pos_q   :
		hit_neg   ? rate_neg_q   :
		hit_ctrl  ? cdr_ctrl_q   :
		hit_stat  ? status_val   : 8'h00;

	always_ff @(posedge clk) begin
		if (srst)
			ack_q <= 1'b0;
		else
			ack_q <= take;
	end

	always_ff @(posedge clk) begin
		if (srst)
			rdata_q <= 32'h0000_0000;
		else if (take)
			rdata_q <= {24'h00_0000, rd_mux};
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// ------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------
	rtc_reg8 #(.RESET(`RTC_RST_FINE_TRIM), .MASK(`RTC_MSK_FINE_TRIM)) u_fine (
		.clk   (clk),
		.srst  (srst),
		.we    (wr_strobe & hit_fine),
		.wdata (wb_dat_i[7:0]),
		.q     (fine_trim_q)
	);
	rtc_reg8 #(.RESET(`RTC_RST_MON_CFG), .MASK(`RTC_MSK_MON_CFG)) u_mon (
		.clk   (clk),
		.srst  (srst),
		.we    (wr_strobe & hit_mon),
		.wdata (wb_dat_i[7:0]),
		.q     (mon_cfg_q)
	);
	rtc_reg8 #(.RESET(`RTC_RST_ADC_SEL), .MASK(`RTC_MSK_ADC_SEL)) u_adc (
		.clk   (clk),
		.srst  (srst),
		.we    (wr_strobe & hit_adc),
		.wdata (wb_dat_i[7:0]),
		.q     (adc_sel_q)
	);
	rtc_reg8 #(.RESET(`RTC_RST_RSSI_OFF), .MASK(`RTC_MSK_FULL)) u_off (
		.clk   (clk),
		.srst  (srst),
		.we    (wr_strobe & hit_off),
		.wdata (wb_dat_i[7:0]),
		.q     (rssi_off_q)
	);
	rtc_reg8 #(.RESET(`RTC_RST_RSSI_SLOPE), .MASK(`RTC_MSK_FULL)) u_slope (
		.clk   (clk),
		.srst  (srst),
		.we    (wr_strobe & hit_slope),
		.wdata (wb_dat_i[7:0]),
		.q     (rssi_slope_q)
	);
	rtc_reg8 #(.RESET(`RTC_RST_RATE_POS), .MASK(`RTC_MSK_FULL)) u_pos (
		.clk   (clk),
		.srst  (srst),
		.we    (wr_strobe & hit_pos),
		.wdata (wb_dat_i[7:0]),
		.q     (rate_pos_q)
	);
	rtc_reg8 #(.RESET(`RTC_RST_RATE_NEG), .MASK(`RTC_MSK_FULL)) u_neg (
		.clk   (clk),
		.srst  (srst),
		.we    (wr_strobe & hit_neg),
		.wdata (wb_dat_i[7:0]),
		.q     (rate_neg_q)
	);
	rtc_reg8 #(.RESET(`RTC_RST_CDR_CTRL), .MASK(`RTC_MSK_CDR_CTRL)) u_ctrl (
		.clk   (clk),
		.srst  (srst),
		.we    (wr_strobe & hit_ctrl),
		.wdata (wb_dat_i[7:0]),
		.q     (cdr_ctrl_q)
	);

	// ------------------------------------------------------------
	// analog controls
	// ------------------------------------------------------------
	assign trim_o.fine_trim_cap_500ff_sel = fine_trim_q[`RTC_BIT_CAP_500FF]; // R1
	assign trim_o.fine_trim_cap_250ff_sel = fine_trim_q[`RTC_BIT_CAP_250FF]; // R1
	assign trim_o.fine_trim_cap_125ff_sel = fine_trim_q[`RTC_BIT_CAP_125FF]; // R2
	assign trim_o.fine_trim_cap_62ff_sel  = fine_trim_q[`RTC_BIT_CAP_62FF]; // R2
	assign rssi_pin_buffer_enable = mon_cfg_q[`RTC_BIT_BUF_EN]; // R3

	wire [2:0] adc_source_select = adc_sel_q[2:0];
	assign adc_route_o.rssi     = adc_source_select == RTC_ADC_RSSI; // R4
	assign adc_route_o.temp     = adc_source_select == RTC_ADC_TEMP; // R4
	assign adc_route_o.vdd_half = adc_source_select == RTC_ADC_VDD_HALF; // R4

	// ------------------------------------------------------------
	// rssi correction
	// ------------------------------------------------------------
	wire signed [9:0]  off_val    = $signed({1'b0, rssi_off_q, 1'b0}) - `RTC_OFFSET_BIAS; // R5
	wire        [15:0] slope_prod = rssi_in.level * rssi_slope_q; // R6
	wire        [8:0]  slope_scl  = slope_prod[`RTC_SLOPE_SHIFT +: 9]; // R6
	wire signed [10:0] rssi_sum   = $signed({2'b00, slope_scl}) + 11'(off_val); // R5

	assign rssi_offset_corr = off_val;

	always_ff @(posedge clk) begin
		if (srst) begin
			rssi_corrected       <= 11'sh000;
			rssi_corrected_valid <= 1'b0;
		end else begin
			rssi_corrected_valid <= rssi_in.valid;
			if (rssi_in.valid)
				rssi_corrected <= rssi_sum;
		end
	end

	// ------------------------------------------------------------
	// data-rate acceptance
	// ------------------------------------------------------------
	wire       rate_limit_check_enable = cdr_ctrl_q[`RTC_BIT_RATE_EN];
	wire       dev_neg = rate_in.dev[8];
	wire [8:0] dev_mag = dev_neg ? 9'(-rate_in.dev) : rate_in.dev;
	wire       pos_ok  = ~dev_neg & (dev_mag <= {1'b0, rate_pos_q}); // R7
	wire       neg_ok  = dev_neg & (dev_mag <= {1'b0, rate_neg_q}); // R8
	wire       rate_ok = ~rate_limit_check_enable | pos_ok | neg_ok; // R9

	always_ff @(posedge clk) begin
		if (srst) begin
			rate_accept       <= 1'b1;
			rate_accept_valid <= 1'b0;
			rate_seen_q       <= 1'b0;
		end else begin
			rate_accept_valid <= rate_in.valid;
			if (rate_in.valid) begin
				rate_accept <= rate_ok;
				rate_seen_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_write(hit);
		wr_strobe && hit;
	endsequence

	property p_cap_hi;
		s_write(hit_fine) |=> trim_o.fine_trim_cap_500ff_sel == $past(wb_dat_i[3])
			&& trim_o.fine_trim_cap_250ff_sel == $past(wb_dat_i[2]);
	endproperty
	a_cap_hi: assert property (p_cap_hi) else $error("500/250 fF switch wrong"); // R1

	property p_cap_lo;
		s_write(hit_fine) |=> trim_o.fine_trim_cap_125ff_sel == $past(wb_dat_i[1])
			&& trim_o.fine_trim_cap_62ff_sel == $past(wb_dat_i[0]);
	endproperty
	a_cap_lo: assert property (p_cap_lo) else $error("125/62.5 fF switch wrong"); // R2

	property p_buf_reset;
		$past(srst) |-> rssi_pin_buffer_enable && trim_o == 4'h0;
	endproperty
	a_buf_reset: assert property (p_buf_reset) else $error("buffer not enabled after reset"); // R3

	property p_adc_route;
		(adc_sel_q[2:0] > 3'h2 |-> adc_route_o == 3'h0) and $onehot0(adc_route_o);
	endproperty
	a_adc_route: assert property (p_adc_route) else $error("adc route wrong"); // R4

	property p_offset;
		s_write(hit_off) |=> rssi_offset_corr == 10'($signed({2'b00, $past(wb_dat_i[7:0])}) * 2 - 256);
	endproperty
	a_offset: assert property (p_offset) else $error("offset mapping wrong"); // R5

	property p_unity;
		rssi_in.valid && rssi_slope_q == `RTC_RST_RSSI_SLOPE && rssi_off_q == `RTC_RST_RSSI_OFF
			|=> rssi_corrected_valid && rssi_corrected == 11'($past(rssi_in.level));
	endproperty
	a_unity: assert property (p_unity) else $error("unity gain not unity"); // R6

	property p_pos_reject;
		rate_in.valid && rate_limit_check_enable && !dev_neg && rate_in.dev[7:0] > rate_pos_q
			|=> !rate_accept;
	endproperty
	a_pos_reject: assert property (p_pos_reject) else $error("fast rate accepted"); // R7

	property p_neg_reject;
		rate_in.valid && rate_limit_check_enable && dev_neg && dev_mag > {1'b0, rate_neg_q}
			|=> !rate_accept;
	endproperty
	a_neg_reject: assert property (p_neg_reject) else $error("slow rate accepted"); // R8

	property p_check_off;
		rate_in.valid && !rate_limit_check_enable |=> rate_accept && rate_accept_valid;
	endproperty
	a_check_off: assert property (p_check_off) else $error("check active while disabled"); // R9

	property p_ack_pulse;
		take |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");

	property p_buf_write;
		s_write(hit_mon) |=> rssi_pin_buffer_enable == $past(wb_dat_i[`RTC_BIT_BUF_EN]);
	endproperty
	a_buf_write: assert property (p_buf_write) else $error("buffer enable write wrong"); // R3

	sequence s_read(hit);
		take && !wb_we_i && hit;
	endsequence

	property p_unused_read;
		s_read(hit_fine) |=> wb_dat_o[31:4] == 28'h000_0000;
	endproperty
	a_unused_read: assert property (p_unused_read) else $error("unused trim bits read nonzero"); // R10

	property p_pos_accept;
		rate_in.valid && rate_limit_check_enable && !dev_neg && rate_in.dev[7:0] <= rate_pos_q
			|=> rate_accept;
	endproperty
	a_pos_accept: assert property (p_pos_accept) else $error("rate in range rejected"); // R7

endmodule

// ===== src/rtc_map.svh
/*
 register map of the receiver trim configuration bank: indices, reset values, field positions.
 assumes: included by the package user; byte address = 4 * index on the wishbone bus.
 */
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define RTC_IDX_FINE_TRIM  8'h8d
`define RTC_IDX_MON_CFG    8'h8e
`define RTC_IDX_ADC_SEL    8'h8f
`define RTC_IDX_RSSI_OFF   8'h90
`define RTC_IDX_RSSI_SLOPE 8'h91
`define RTC_IDX_RATE_POS   8'h92
`define RTC_IDX_RATE_NEG   8'h93
`define RTC_IDX_CDR_CTRL   8'ha0
`define RTC_IDX_STATUS     8'ha1

// ------------------------------------------------------------
// reset values and writable masks
// ------------------------------------------------------------
`define RTC_RST_FINE_TRIM  8'h00
`define RTC_RST_MON_CFG    8'h01
`define RTC_RST_ADC_SEL    8'h00
`define RTC_RST_RSSI_OFF   8'h80
`define RTC_RST_RSSI_SLOPE 8'h80
`define RTC_RST_RATE_POS   8'h1e
`define RTC_RST_RATE_NEG   8'h23
`define RTC_RST_CDR_CTRL   8'h00
`define RTC_MSK_FINE_TRIM  8'h0f
`define RTC_MSK_MON_CFG    8'h01
`define RTC_MSK_ADC_SEL    8'h07
`define RTC_MSK_FULL       8'hff
`define RTC_MSK_CDR_CTRL   8'h01

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RTC_BIT_CAP_500FF  3
`define RTC_BIT_CAP_250FF  2
`define RTC_BIT_CAP_125FF  1
`define RTC_BIT_CAP_62FF   0
`define RTC_BIT_BUF_EN     0
`define RTC_BIT_RATE_EN    0
`define RTC_BIT_ST_ACCEPT  0
`define RTC_BIT_ST_SEEN    1
`define RTC_SLOPE_SHIFT    7
`define RTC_OFFSET_BIAS    10'sh100

`endif

// ===== src/rtc_pkg.sv
/*
 types shared by the receiver trim configuration bank.
 assumes: nothing beyond a systemverilog compiler.
 */
package rtc_pkg;

	typedef struct packed {
		logic fine_trim_cap_500ff_sel;
		logic fine_trim_cap_250ff_sel;
		logic fine_trim_cap_125ff_sel;
		logic fine_trim_cap_62ff_sel;
	} rtc_trim_s;

	typedef enum logic [2:0] {
		RTC_ADC_RSSI     = 3'h0,
		RTC_ADC_TEMP     = 3'h1,
		RTC_ADC_VDD_HALF = 3'h2
	} rtc_adc_src_e;

	typedef struct packed {
		logic vdd_half;
		logic temp;
		logic rssi;
	} rtc_adc_route_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] level;
	} rtc_rssi_s;

	typedef struct packed {
		logic             valid;
		logic signed [8:0] dev;
	} rtc_rate_s;

endpackage

// ===== src/rtc_reg8.sv
/*
 one byte-wide configuration register with a writable-bit mask.
 assumes: write strobe and data come from the bus slave on the same clock.
 */
module rtc_reg8 #(
	parameter logic [7:0] RESET = 8'h00,
	parameter logic [7:0] MASK  = 8'hff
) (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output logic      [7:0] q
);

	always_ff @(posedge clk) begin
		if (srst)
			q <= RESET;
		else if (we)
			q <= wdata & MASK; // R10
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_unused_zero;
		@(posedge clk) disable iff (srst) (q & ~MASK) == 8'h00;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused bits not zero"); // R10

	property p_write_lands;
		@(posedge clk) disable iff (srst) we |=> q == ($past(wdata) & MASK);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write did not land");

endmodule

// ===== sim/rtc_trim_regs_tb.sv
/*
 self-checking bench for the receiver trim configuration bank.
 assumes: package compiled first; one 100 MHz clock; classic wishbone with one-cycle ack.
 */
module rtc_trim_regs_tb
	import rtc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] rst;
		logic [7:0] wd;
		logic [7:0] rb;
	} rtc_tb_row_s;

	logic                  clk = 1'b0;
	logic                  srst = 1'b1;
	logic                  wb_cyc_i = 1'b0;
	logic                  wb_stb_i = 1'b0;
	logic                  wb_we_i = 1'b0;
	logic [9:0]            wb_adr_i = 10'h000;
	logic [3:0]            wb_sel_i = 4'h0;
	logic [31:0]           wb_dat_i = 32'h00000000;
	logic [31:0]           wb_dat_o;
	logic                  wb_ack_o;
	rtc_rssi_s             rssi_in = '0;
	rtc_rate_s             rate_in = '0;
	rtc_trim_s             trim_o;
	logic                  rssi_pin_buffer_enable;
	rtc_adc_route_s        adc_route_o;
	logic signed [9:0]     rssi_offset_corr;
	logic signed [10:0]    rssi_corrected;
	logic                  rssi_corrected_valid;
	logic                  rate_accept;
	logic                  rate_accept_valid;
	int                    err_count = 0;
	int                    checked = 0;
	int                    cycles = 0;
	logic [31:0]           rd;
	rtc_tb_row_s           rows [8] = '{
		'{8'h8d, 8'h00, 8'hff, 8'h0f}, '{8'h8e, 8'h01, 8'hff, 8'h01}, '{8'h8f, 8'h00, 8'hff, 8'h07},
		'{8'h90, 8'h80, 8'h00, 8'h00}, '{8'h91, 8'h80, 8'h55, 8'h55}, '{8'h92, 8'h1e, 8'ha5, 8'ha5},
		'{8'h93, 8'h23, 8'h5a, 8'h5a}, '{8'ha0, 8'h00, 8'hff, 8'h01}};

	rtc_trim_regs #(.AW(10)) rtc_trim_regs_inst (
		.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .rssi_in(rssi_in), .rate_in(rate_in), .trim_o(trim_o),
		.rssi_pin_buffer_enable(rssi_pin_buffer_enable), .adc_route_o(adc_route_o),
		.rssi_offset_corr(rssi_offset_corr), .rssi_corrected(rssi_corrected),
		.rssi_corrected_valid(rssi_corrected_valid), .rate_accept(rate_accept),
		.rate_accept_valid(rate_accept_valid));

	always #5 clk = ~clk;

	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		if (err_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles > 5000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// request held until the edge that samples ack; data taken there
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] sel);
		int n;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= {24'h000000, wd};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		wb(1'b1, idx, wd, 4'hf);
		@(posedge clk);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
		wb(1'b0, idx, 8'h00, 4'hf);
		chk(what, {24'h000000, exp}, rd);
	endtask

	task automatic rssi_shot(input logic [7:0] lvl, input int expv);
		@(posedge clk);
		rssi_in <= '{valid: 1'b1, level: lvl};
		@(posedge clk);
		rssi_in.valid <= 1'b0;
		@(posedge clk);
		chk("rssi_corrected_valid", 32'h1, {31'h0, rssi_corrected_valid});
		chk("rssi_corrected", 32'(expv), 32'(rssi_corrected));
	endtask

	task automatic rate_shot(input logic signed [8:0] dev, input logic exp);
		@(posedge clk);
		rate_in <= '{valid: 1'b1, dev: dev};
		@(posedge clk);
		rate_in.valid <= 1'b0;
		@(posedge clk);
		chk("rate_accept_valid", 32'h1, {31'h0, rate_accept_valid});
		chk("rate_accept", {31'h0, exp}, {31'h0, rate_accept});
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("trim_o", 32'h0, {28'h0, trim_o});
		chk("rssi_pin_buffer_enable", 32'h1, {31'h0, rssi_pin_buffer_enable});
		chk("adc_route_o", 32'h1, {29'h0, adc_route_o});
		chk("rssi_offset_corr", 32'h0, 32'(rssi_offset_corr));
		foreach (rows[i]) begin
			rdchk(rows[i].idx, rows[i].rst, "reset value");
		end
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			rdchk(rows[i].idx, rows[i].rb, "readback");
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h8d, 8'(1 << i));
			chk("trim_o", 32'(1 << i), {28'h0, trim_o});
		end
		wr(8'h8e, 8'h00);
		chk("rssi_pin_buffer_enable", 32'h0, {31'h0, rssi_pin_buffer_enable});
		wr(8'h8e, 8'h01);
		chk("rssi_pin_buffer_enable", 32'h1, {31'h0, rssi_pin_buffer_enable});
		for (int c = 0; c < 8; c++) begin
			wr(8'h8f, 8'(c));
			chk("adc_route_o", (c < 3) ? 32'(1 << c) : 32'h0, {29'h0, adc_route_o});
		end
		wr(8'h90, 8'h00);
		chk("rssi_offset_corr", 32'(-256), 32'(rssi_offset_corr));
		wr(8'h90, 8'hff);
		chk("rssi_offset_corr", 32'(254), 32'(rssi_offset_corr));
		wr(8'h90, 8'h80);
		wr(8'h91, 8'hff);
		rssi_shot(8'hff, 508);
		wr(8'h91, 8'h80);
		rssi_shot(8'h7b, 123);
		wr(8'h90, 8'h00);
		rssi_shot(8'h7b, -133);
		wr(8'h91, 8'h00);
		rssi_shot(8'hff, -256);
		wr(8'h92, 8'h1e);
		wr(8'h93, 8'h23);
		wr(8'ha0, 8'h00);
		rate_shot(-9'sd256, 1'b1);
		wr(8'ha0, 8'h01);
		rate_shot(9'sd30, 1'b1);
		rate_shot(9'sd31, 1'b0);
		rate_shot(-9'sd35, 1'b1);
		rate_shot(-9'sd36, 1'b0);
		rate_shot(-9'sd256, 1'b0);
		rdchk(8'ha1, 8'h02, "status after checks");
		rdchk(8'h50, 8'h00, "unmapped read");
		wb(1'b1, 8'h92, 8'h77, 4'he);
		rdchk(8'h92, 8'h1e, "write without sel0");
		wr(8'h8e, 8'h00);
		wr(8'h93, 8'h5a);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		chk("rssi_pin_buffer_enable", 32'h1, {31'h0, rssi_pin_buffer_enable});
		chk("rate_accept", 32'h1, {31'h0, rate_accept});
		rdchk(8'ha1, 8'h01, "status after reset");
		rdchk(8'h8d, 8'h00, "fine trim after reset");
		rdchk(8'h93, 8'h23, "negative threshold after reset");
		wrap_up();
	end
endmodule
